/* File: rrn_exec.v */
// Purpose: executes the rotate-right-without-carry byte instruction in one four-phase cycle
// Assumes: file memory sits outside; its read data is valid the clock after FILE_RD
// Notes:   one clock per phase, so an instruction takes four clocks from acceptance
//          INSTR_VALID is ignored while BUSY is high; a refused offer must be repeated
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/10ps
`include "rrn_exec_map.vh"

module rrn_exec (
  input  wire        REF_CLK,
  input  wire        RESETN,
  input  wire [15:0] INSTR,
  input  wire        INSTR_VALID,
  input  wire [7:0]  FILE_RDATA,
  input  wire [2:0]  ADDR,
  input  wire [7:0]  WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [7:0]  RDATA,
  output reg  [11:0] FILE_ADDR,
  output reg         FILE_RD,
  output reg         FILE_WR,
  output reg  [7:0]  FILE_WDATA,
  output reg         BUSY,
  output reg         DONE,
  output reg         ILLEGAL
);

  // ***************************************************************
  // phase states
  // ***************************************************************
  localparam [3:0] Q1 = 4'h1;
  localparam [3:0] Q2 = 4'h2;
  localparam [3:0] Q3 = 4'h4;
  localparam [3:0] Q4 = 4'h8;

  reg  [3:0]  state_reg;
  reg  [3:0]  state_next;
  reg         ext_en_reg;
  reg  [3:0]  bank_reg;
  reg  [7:0]  wreg_reg;
  reg  [`RRN_ST_WIDTH-1:0] status_reg;
  reg  [11:0] idx_reg;
  reg         dest_reg;
  reg  [7:0]  result_reg;
  reg  [11:0] ea_next;
  reg  [7:0]  rdata_next;

  wire [7:0]  f_addr  = INSTR[7:0];
  wire        a_bit   = INSTR[`RRN_A_BIT];
  wire        is_rrn  = (INSTR[`RRN_OPC_HI:`RRN_OPC_LO] == `RRN_OPC_VAL);
  wire [7:0]  rotated;
  wire        take    = (state_reg == Q1) && INSTR_VALID;

  // ***************************************************************
  // rotate right by one; carry is not an input here
  // ***************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : rot_bit
      assign rotated[gi] = FILE_RDATA[(gi + 1) % 8];
    end
  endgenerate

  // ***************************************************************
  // operand address
  // ***************************************************************
  always @*
  begin
    if (!a_bit && ext_en_reg && (f_addr <= `RRN_ILO_LIMIT))
      ea_next = idx_reg + {4'h0, f_addr};
    else if (!a_bit)
      ea_next = (f_addr < `RRN_ACC_SPLIT) ? {4'h0, f_addr} : {`RRN_ACC_HI_BANK, f_addr};
    else
      ea_next = {bank_reg, f_addr};
  end

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      Q1:      if (INSTR_VALID && is_rrn) state_next = Q2;
      Q2:      state_next = Q3;
      Q3:      state_next = Q4;
      Q4:      state_next = Q1;
      default: state_next = Q1;
    endcase
  end

  // ***************************************************************
  // phase sequencing and strobes
  // ***************************************************************
  always @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_reg <= Q1;
      FILE_RD   <= 1'h0;
      FILE_WR   <= 1'h0;
      BUSY      <= 1'h0;
      DONE      <= 1'h0;
      ILLEGAL   <= 1'h0;
    end
    else
    begin
      state_reg <= state_next;
      FILE_RD   <= take && is_rrn;
      FILE_WR   <= (state_reg == Q3) && dest_reg;
      DONE      <= (state_reg == Q3);
      ILLEGAL   <= take && !is_rrn;
      BUSY      <= (state_next != Q1);
    end
  end

  // ***************************************************************
  // operand capture at decode
  // ***************************************************************
  // latched only in Q1, so a new INSTR offered while busy cannot move it
  always @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      FILE_ADDR <= `RRN_RST_FADDR;
      dest_reg  <= `RRN_RST_DEST;
    end
    else if (take && is_rrn)
    begin
      FILE_ADDR <= ea_next;
      dest_reg  <= INSTR[`RRN_D_BIT];
    end
  end

  // ***************************************************************
  // rotated result, captured in Q3
  // ***************************************************************
  always @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      result_reg <= `RRN_RST_BYTE;
      FILE_WDATA <= `RRN_RST_BYTE;
    end
    else if (state_reg == Q3)
    begin
      result_reg <= rotated;
      FILE_WDATA <= rotated;
    end
  end

  // ***************************************************************
  // control, bank and index registers
  // ***************************************************************
  always @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ext_en_reg <= `RRN_RST_CTRL;
      bank_reg   <= `RRN_RST_BANK;
      idx_reg    <= `RRN_RST_IDX;
    end
    else if (WR)
    begin
      case (ADDR)
        `RRN_OFS_CTRL:  ext_en_reg    <= WDATA[`RRN_CTRL_EXT_BIT];
        `RRN_OFS_BANK:  bank_reg      <= WDATA[3:0];
        `RRN_OFS_IDXLO: idx_reg[7:0]  <= WDATA;
        `RRN_OFS_IDXHI: idx_reg[11:8] <= WDATA[3:0];
        default:        ;
      endcase
    end
  end

  // ***************************************************************
  // working register and status; the Q4 write-back wins over a port write
  // ***************************************************************
  always @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      wreg_reg   <= `RRN_RST_WREG;
      status_reg <= `RRN_RST_STATUS;
    end
    else
    begin
      if (WR && (ADDR == `RRN_OFS_WREG))
        wreg_reg <= WDATA;
      if (WR && (ADDR == `RRN_OFS_STATUS))
        status_reg <= WDATA[`RRN_ST_WIDTH-1:0];
      // placed last so a same-cycle software write cannot undo the flag update
      if (state_reg == Q4)
      begin
        if (!dest_reg)
          wreg_reg <= result_reg;
        status_reg[`RRN_ST_N_BIT] <= result_reg[7];
        status_reg[`RRN_ST_Z_BIT] <= (result_reg == 8'h00);
      end
    end
  end

  // ***************************************************************
  // register read path
  // ***************************************************************
  always @*
  begin
    rdata_next = 8'h00;
    if (RD)
    begin
      case (ADDR)
        `RRN_OFS_CTRL:   rdata_next = {7'h00, ext_en_reg};
        `RRN_OFS_BANK:   rdata_next = {4'h0, bank_reg};
        `RRN_OFS_WREG:   rdata_next = wreg_reg;
        `RRN_OFS_STATUS: rdata_next = {3'h0, status_reg};
        `RRN_OFS_IDXLO:  rdata_next = idx_reg[7:0];
        `RRN_OFS_IDXHI:  rdata_next = {4'h0, idx_reg[11:8]};
        `RRN_OFS_PHASE:  rdata_next = {4'h0, state_reg};
        default:         rdata_next = 8'h00;
      endcase
    end
  end

  // back to zero after one cycle so stale read data never lingers
  always @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      RDATA <= `RRN_RST_BYTE;
    else
      RDATA <= rdata_next;
  end

endmodule

/* File: rrn_exec_map.vh */
// Purpose: constants for the rotate-right-without-carry execution block
// Assumes: included by rrn_exec.v only; 250 MHz REF_CLK, one phase per clock
// Notes:   offsets are word indices on the plain register port
//
// Operation
// - The instruction is a 16-bit word: a six-bit fixed opcode, then d, then a, then an eight-bit file address.
// - The operand byte is rotated right by one, old bit 0 lands in bit 7, and carry is never used or changed.
// - With d at 0 the result goes to the working register and the source stays; with d at 1 it goes back to the file.
// - With a at 0 the operand comes from the access bank, ignoring the bank select register; with a at 1 that register picks the bank.
// - With a at 0, the extended set enabled and an address of 95 or less, the address is the indexed base plus the literal offset.
// - Only the negative and zero flags are updated; every other status flag keeps its value.
// - One program word, one instruction cycle: decode, read file, compute, write destination in four quarters.
`ifndef RRN_EXEC_MAP_VH
`define RRN_EXEC_MAP_VH

// ***************************************************************
// instruction encoding
// ***************************************************************
`define RRN_OPC_HI        15
`define RRN_OPC_LO        10
`define RRN_OPC_VAL       6'h10
`define RRN_D_BIT         9
`define RRN_A_BIT         8
`define RRN_ILO_LIMIT     8'h5f
`define RRN_ACC_SPLIT     8'h60
`define RRN_ACC_HI_BANK   4'hf

// ***************************************************************
// register port offsets
// ***************************************************************
`define RRN_OFS_CTRL      3'h0
`define RRN_OFS_BANK      3'h1
`define RRN_OFS_WREG      3'h2
`define RRN_OFS_STATUS    3'h3
`define RRN_OFS_IDXLO     3'h4
`define RRN_OFS_IDXHI     3'h5
`define RRN_OFS_PHASE     3'h6

// ***************************************************************
// field positions and reset values
// ***************************************************************
`define RRN_CTRL_EXT_BIT  0
`define RRN_ST_Z_BIT      2
`define RRN_ST_N_BIT      4
`define RRN_ST_WIDTH      5
`define RRN_RST_CTRL      1'h0
`define RRN_RST_BANK      4'h0
`define RRN_RST_WREG      8'h00
`define RRN_RST_STATUS    5'h00
`define RRN_RST_IDX       12'h000
`define RRN_RST_FADDR     12'h000
`define RRN_RST_BYTE      8'h00
`define RRN_RST_DEST      1'h1

`endif

/* File: rrn_exec_monitor.sv */
// Purpose: port checker for rrn_exec
// Assumes: one clock, RESETN asynchronous active low
// Notes:   phase Q1 is read as BUSY low
`timescale 1ns/10ps
module rrn_exec_monitor (
  input wire        REF_CLK,
  input wire        RESETN,
  input wire [15:0] INSTR,
  input wire        INSTR_VALID,
  input wire [7:0]  FILE_RDATA,
  input wire [11:0] FILE_ADDR,
  input wire        FILE_RD,
  input wire        FILE_WR,
  input wire [7:0]  FILE_WDATA,
  input wire        BUSY,
  input wire        DONE,
  input wire        ILLEGAL
);
  // ************************
  // instruction checks
  // ************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  sequence take_s;
    INSTR_VALID && !BUSY && INSTR[15:10] == 6'h10;
  endsequence
  sequence walk_s;
    FILE_RD && BUSY ##1 !FILE_RD && BUSY ##1 DONE && BUSY ##1 !BUSY;
  endsequence
  phase_walk_a: assert property (take_s |=> walk_s)
    else $error("phase walk broken");
  file_dest_a: assert property (take_s ##0 INSTR[9] |=> ##2 FILE_WR)
    else $error("missing file write");
  wreg_dest_a: assert property (take_s ##0 !INSTR[9] |=> ##2 !FILE_WR)
    else $error("file written for d 0");
  rotate_data_a: assert property (FILE_RD ##1 1'b1 |=> FILE_WDATA == {$past(FILE_RDATA[0]), $past(FILE_RDATA[7:1])})
    else $error("bad rotate");
  bank_addr_a: assert property (take_s ##0 INSTR[8] |=> FILE_ADDR[7:0] == $past(INSTR[7:0]))
    else $error("bad banked address");
  access_hi_a: assert property (take_s ##0 !INSTR[8] && INSTR[7:0] > 8'h5f |=> FILE_ADDR == {4'hf, $past(INSTR[7:0])})
    else $error("bad access address");
  bad_op_a: assert property (INSTR_VALID && !BUSY && INSTR[15:10] != 6'h10 |=> ILLEGAL && !FILE_RD && !BUSY)
    else $error("wrong opcode ran");
  write_done_a: assert property (FILE_WR |-> DONE)
    else $error("file write outside Q4");
endmodule
bind rrn_exec rrn_exec_monitor i_mon (.REF_CLK(REF_CLK), .RESETN(RESETN), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID),
  .FILE_RDATA(FILE_RDATA), .FILE_ADDR(FILE_ADDR), .FILE_RD(FILE_RD), .FILE_WR(FILE_WR),
  .FILE_WDATA(FILE_WDATA), .BUSY(BUSY), .DONE(DONE), .ILLEGAL(ILLEGAL));

/* File: tb_top.sv */
// Purpose: self-checking bench for rrn_exec
// Assumes: file read data offered only in the cycle after FILE_RD
// Notes:   expectations come from the encoding, never from outputs
`timescale 1ns/10ps
module tb_top;
  // ************************
  // stimulus and checks
  // ************************
  logic        REF_CLK = 0, RESETN = 0, INSTR_VALID = 0, WR = 0, RD = 0;
  logic [15:0] INSTR = 16'h0000;
  logic [7:0]  FILE_RDATA = 8'h00, WDATA = 8'h00;
  logic [2:0]  ADDR = 3'h0;
  wire  [7:0]  RDATA, FILE_WDATA;
  wire  [11:0] FILE_ADDR;
  wire         FILE_RD, FILE_WR, BUSY, DONE, ILLEGAL;
  int          err_count = 0, checks = 0;
  always #2 REF_CLK = ~REF_CLK;
  rrn_exec i_dut (.REF_CLK(REF_CLK), .RESETN(RESETN), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID),
    .FILE_RDATA(FILE_RDATA), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .FILE_ADDR(FILE_ADDR), .FILE_RD(FILE_RD), .FILE_WR(FILE_WR), .FILE_WDATA(FILE_WDATA),
    .BUSY(BUSY), .DONE(DONE), .ILLEGAL(ILLEGAL));
  task tally_and_finish;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task cmp(input string n, input logic [11:0] e, input logic [11:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge REF_CLK) {ADDR, WDATA, WR} <= {a, d, 1'b1};
    @(posedge REF_CLK) WR <= 0;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge REF_CLK) {ADDR, RD} <= {a, 1'h1};
    @(posedge REF_CLK) RD <= 1'h0;
    #1 cmp("RDATA", e, RDATA);
    @(posedge REF_CLK);
  endtask
  // returns on the edge before Q1, so calls run back to back
  task exec(input logic [15:0] ins, input logic [7:0] fd, input logic [11:0] ea);
    {INSTR, INSTR_VALID, FILE_RDATA} <= {ins, 1'b1, ~fd};
    @(posedge REF_CLK) INSTR_VALID <= 0;
    #1 cmp("FILE_ADDR", ea, FILE_ADDR);
    cmp("FILE_RD", 1, FILE_RD);
    @(posedge REF_CLK) FILE_RDATA <= fd;
    @(posedge REF_CLK) FILE_RDATA <= ~fd;
    #1 cmp("FILE_WDATA", {fd[0], fd[7:1]}, FILE_WDATA);
    cmp("FILE_WR", ins[9], FILE_WR);
    cmp("DONE", 1, DONE);
    @(posedge REF_CLK);
  endtask
  task t_flags;
    wr(3'h3, 8'h0b);
    wr(3'h1, 8'h03);
    exec(16'h4312, 8'hd7, 12'h312);
    exec(16'h4070, 8'h01, 12'hf70);
    rd(3'h2, 8'h80);
    rd(3'h3, 8'h1b);
    exec(16'h4020, 8'h00, 12'h020);
    rd(3'h2, 8'h00);
    rd(3'h3, 8'h0f);
    $display("test flags done");
  endtask
  task t_index;
    wr(3'h0, 8'h01);
    wr(3'h4, 8'hfe);
    wr(3'h5, 8'h01);
    rd(3'h4, 8'hfe);
    exec(16'h425f, 8'h02, 12'h25d);
    exec(16'h4260, 8'h03, 12'hf60);
    exec(16'h4360, 8'h80, 12'h360);
    rd(3'h3, 8'h0b);
    $display("test index done");
  endtask
  task t_illegal;
    {INSTR, INSTR_VALID} <= {16'h4800, 1'b1};
    @(posedge REF_CLK) INSTR_VALID <= 0;
    #1 cmp("ILLEGAL", 1, ILLEGAL);
    cmp("FILE_RD", 0, FILE_RD);
    cmp("BUSY", 0, BUSY);
    @(posedge REF_CLK);
    $display("test illegal done");
  endtask
  // a second offer held high while busy must be ignored
  task t_busy;
    {INSTR, INSTR_VALID, FILE_RDATA} <= {16'h4312, 1'h1, 8'h55};
    @(posedge REF_CLK) INSTR <= 16'h4070;
    #1 cmp("FILE_ADDR", 12'h312, FILE_ADDR);
    @(posedge REF_CLK) {INSTR_VALID, FILE_RDATA} <= {1'h0, 8'h2a};
    #1 cmp("FILE_RD", 0, FILE_RD);
    cmp("FILE_ADDR", 12'h312, FILE_ADDR);
    @(posedge REF_CLK) FILE_RDATA <= 8'h55;
    #1 cmp("FILE_WDATA", 8'h15, FILE_WDATA);
    cmp("FILE_WR", 1, FILE_WR);
    @(posedge REF_CLK);
    $display("test busy done");
  endtask
  task t_reset;
    RESETN <= 1'h0;
    @(posedge REF_CLK) RESETN <= 1'h1;
    rd(3'h3, 8'h00);
    rd(3'h1, 8'h00);
    rd(3'h6, 8'h01);
    $display("test reset done");
  endtask
  initial
  begin
    repeat (16) @(posedge REF_CLK);
    RESETN <= 1;
    t_flags;
    t_index;
    t_busy;
    t_illegal;
    t_reset;
    tally_and_finish;
  end
  initial
  begin
    #20000;
    err_count++;
    tally_and_finish;
  end
endmodule
